// ===== verilog/rpg_regs.svh
// constants for the channel g/h receive upper-bit output block
`ifndef RPG_REGS_SVH
`define RPG_REGS_SVH

`define RPG_WORD_W      10
`define RPG_LANE_W      5
`define RPG_FIFO_DEPTH  16
`define RPG_FIFO_W      22
`define RPG_MODE_MUX    2'h0
`define RPG_MODE_NIBBLE 2'h2
`define RPG_OUT_RST     10'h000

`endif

// ===== verilog/rpg_pkg.sv
// types for the channel g/h receive upper-bit output block
package rpg_pkg;
    typedef enum logic [1:0] {
        RPG_IF_MUX,
        RPG_IF_NIBBLE,
        RPG_IF_RESERVED
    } rpg_if_t;

    typedef enum logic {
        RPG_HALF_FALL,
        RPG_HALF_RISE
    } rpg_half_t;
endpackage : rpg_pkg

// ===== verilog/rpg_top.sv
// receive output fifo and g/h upper-bit ddr output launcher
`timescale 1ns/1ps
`include "rpg_regs.svh"

// --------------------------------------------------------------------
// generic valid/ready fifo
// --------------------------------------------------------------------
module rpg_fifo #(
    parameter int WIDTH = `RPG_FIFO_W,
    parameter int DEPTH = `RPG_FIFO_DEPTH
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr_reg];
    assign count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge core_clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_reg  <= '0;
            rd_ptr_reg  <= '0;
            count_reg   <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            end
            count_reg   <= count_next;
            // full and empty registered so ready reaches the source cleanly
            in_ready_o  <= (count_next != (AW+1)'(DEPTH));
            out_valid_o <= (count_next != '0);
        end
    end
endmodule : rpg_fifo

// --------------------------------------------------------------------
// top: drains one g/h word pair per receive clock period
// --------------------------------------------------------------------
module rpg_top (
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     rx_clk_i,
    input  wire logic [1:0]               mode_i,
    input  wire logic                     code_en_pin_i,
    input  wire logic                     code_en_mgmt_i,
    input  wire logic                     word_valid_i,
    input  wire logic [`RPG_WORD_W-1:0]   g_word_i,
    input  wire logic                     g_kflag_i,
    input  wire logic [`RPG_WORD_W-1:0]   h_word_i,
    input  wire logic                     h_kflag_i,
    output logic                          word_ready_o,
    output logic [7:0]                    rx_gh_low_bus_o,
    output logic                          rx_gh_bit8_kflag_o,
    output logic                          rx_gh_bit9_o
);
    import rpg_pkg::*;

    // ----------------------------------------------------------------
    // lane mapping helpers
    // ----------------------------------------------------------------
    // one channel, one edge, nibble mode: five pins of the lane
    function automatic logic [`RPG_LANE_W-1:0] nib_lane(
        input logic [`RPG_WORD_W-1:0] w,
        input logic                   k,
        input logic                   coded,
        input rpg_half_t              half
    );
        logic [`RPG_LANE_W-1:0] r;
        r = '0;
        if (!coded)
            r = (half == RPG_HALF_FALL) ? w[4:0] : w[9:5];
        else if (half == RPG_HALF_FALL)
            r = {1'b0, w[3:0]};
        else
            r = {w[7], k, w[6:4]};
        return r;
    endfunction : nib_lane

    // one channel, multiplexed mode: all ten pins
    function automatic logic [`RPG_WORD_W-1:0] mux_lane(
        input logic [`RPG_WORD_W-1:0] w,
        input logic                   k,
        input logic                   coded
    );
        logic [`RPG_WORD_W-1:0] r;
        r = coded ? {1'b0, k, w[7:0]} : w;
        return r;
    endfunction : mux_lane

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] rclk_sync_reg;
    logic [1:0] mode_meta_reg;
    logic [1:0] mode_reg;
    logic       code_meta_reg;
    logic       code_pin_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            rclk_sync_reg <= 3'h0;
            mode_meta_reg <= 2'h0;
            mode_reg      <= 2'h0;
            code_meta_reg <= 1'b0;
            code_pin_reg  <= 1'b0;
        end
        else
        begin
            rclk_sync_reg <= {rclk_sync_reg[1:0], rx_clk_i};
            mode_meta_reg <= mode_i;
            mode_reg      <= mode_meta_reg;
            code_meta_reg <= code_en_pin_i;
            code_pin_reg  <= code_meta_reg;
        end
    end

    // stage 0 is only read by stage 1; edges judged from stages 1 and 2
    logic      rclk_rise;
    logic      rclk_fall;
    logic      coded;
    rpg_if_t   if_mode;

    assign rclk_rise = rclk_sync_reg[1] && !rclk_sync_reg[2];
    assign rclk_fall = !rclk_sync_reg[1] && rclk_sync_reg[2];
    assign coded     = code_pin_reg || code_en_mgmt_i;

    always_comb
    begin
        unique case (mode_reg)
            `RPG_MODE_MUX:    if_mode = RPG_IF_MUX;
            `RPG_MODE_NIBBLE: if_mode = RPG_IF_NIBBLE;
            default:          if_mode = RPG_IF_RESERVED;
        endcase
    end

    // ----------------------------------------------------------------
    // word fifo
    // ----------------------------------------------------------------
    logic                   fifo_valid;
    logic [`RPG_FIFO_W-1:0] fifo_data;
    logic                   fifo_pop;

    // one pair taken per period, at the falling edge that opens it
    assign fifo_pop = rclk_fall;

    rpg_fifo #(
        .WIDTH (`RPG_FIFO_W),
        .DEPTH (`RPG_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (word_valid_i),
        .in_data_i   ({h_kflag_i, h_word_i, g_kflag_i, g_word_i}),
        .in_ready_o  (word_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_pop)
    );

    // ----------------------------------------------------------------
    // current pair held for the whole receive clock period
    // ----------------------------------------------------------------
    logic [`RPG_WORD_W-1:0] g_word_reg;
    logic [`RPG_WORD_W-1:0] h_word_reg;
    logic                   g_k_reg;
    logic                   h_k_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            g_word_reg <= `RPG_OUT_RST;
            h_word_reg <= `RPG_OUT_RST;
            g_k_reg    <= 1'b0;
            h_k_reg    <= 1'b0;
        end
        else if (rclk_fall)
        begin
            // underrun sends an all-zero pair rather than repeating stale data
            g_word_reg <= fifo_valid ? fifo_data[9:0]   : `RPG_OUT_RST;
            g_k_reg    <= fifo_valid && fifo_data[10];
            h_word_reg <= fifo_valid ? fifo_data[20:11] : `RPG_OUT_RST;
            h_k_reg    <= fifo_valid && fifo_data[21];
        end
    end

    // ----------------------------------------------------------------
    // edge launch
    // ----------------------------------------------------------------
    logic [`RPG_WORD_W-1:0] fall_pins;
    logic [`RPG_WORD_W-1:0] rise_pins;
    logic [`RPG_WORD_W-1:0] pins_reg;

    // falling pins come from the fifo head, so they launch on the pop edge
    always_comb
    begin
        logic [`RPG_WORD_W-1:0] gw;
        logic [`RPG_WORD_W-1:0] hw;
        logic                   gk;
        logic                   hk;
        gw = fifo_valid ? fifo_data[9:0]   : `RPG_OUT_RST;
        gk = fifo_valid && fifo_data[10];
        hw = fifo_valid ? fifo_data[20:11] : `RPG_OUT_RST;
        hk = fifo_valid && fifo_data[21];
        fall_pins = `RPG_OUT_RST;
        rise_pins = `RPG_OUT_RST;
        unique case (if_mode)
            RPG_IF_MUX:
            begin
                fall_pins = mux_lane(gw, gk, coded);
                rise_pins = mux_lane(h_word_reg, h_k_reg, coded);
            end
            RPG_IF_NIBBLE:
            begin
                fall_pins = {nib_lane(hw, hk, coded, RPG_HALF_FALL),
                             nib_lane(gw, gk, coded, RPG_HALF_FALL)};
                rise_pins = {nib_lane(h_word_reg, h_k_reg, coded, RPG_HALF_RISE),
                             nib_lane(g_word_reg, g_k_reg, coded, RPG_HALF_RISE)};
            end
            RPG_IF_RESERVED:
            begin
                // reserved codes: pins stay low
                fall_pins = `RPG_OUT_RST;
                rise_pins = `RPG_OUT_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            pins_reg <= `RPG_OUT_RST;
        end
        else if (rclk_fall)
        begin
            pins_reg <= fall_pins;
        end
        else if (rclk_rise)
        begin
            pins_reg <= rise_pins;
        end
    end

    assign rx_gh_low_bus_o    = pins_reg[7:0];
    assign rx_gh_bit8_kflag_o = pins_reg[8];
    assign rx_gh_bit9_o       = pins_reg[9];
endmodule : rpg_top

// ===== test/rpg_props.sv
// checker for the g/h receive upper-bit output block
`timescale 1ns/1ps
module rpg_props (
    input wire logic       core_clk_i,
    input wire logic       rst_n_i,
    input wire logic       rx_clk_i,
    input wire logic [1:0] mode_i,
    input wire logic       code_en_pin_i,
    input wire logic       code_en_mgmt_i,
    input wire logic       word_valid_i,
    input wire logic       word_ready_o,
    input wire logic [7:0] rx_gh_low_bus_o,
    input wire logic       rx_gh_bit8_kflag_o,
    input wire logic       rx_gh_bit9_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       rx_q;
    logic [3:0] age_q;
    logic [7:0] idle_q;
    logic [9:0] pins;
    logic       coded;
    assign pins  = {rx_gh_bit9_o, rx_gh_bit8_kflag_o, rx_gh_low_bus_o};
    assign coded = code_en_pin_i | code_en_mgmt_i;
    // age counts core cycles since the link clock level was seen to move
    always_ff @(posedge core_clk_i)
    begin
        rx_q   <= rx_clk_i;
        age_q  <= (rx_clk_i != rx_q) ? 4'h1 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
        idle_q <= word_valid_i ? 8'h00 : ((idle_q == 8'hff) ? idle_q : idle_q + 8'h01);
    end
    edge_hold_a: assert property (rx_clk_i != rx_q |-> $stable(pins))
        else $error("pins moved on the link edge sample");
    pins_late_a: assert property ($changed(pins) |-> age_q inside {[4'h1:4'h3]})
        else $error("pins moved outside the launch slot");
    reserved_quiet_a: assert property (mode_i[0] [*8] |-> pins == 10'h000)
        else $error("pins driven in a reserved mode");
    mux_coded_a: assert property ((mode_i == 2'h0 && coded) [*8] |-> !rx_gh_bit9_o)
        else $error("bit9 driven in coded multiplexed mode");
    nib_fall_a: assert property ((mode_i == 2'h2 && coded) [*8]
        ##0 (age_q == 4'h3 && !rx_clk_i) |-> !rx_gh_bit9_o && !rx_gh_low_bus_o[4])
        else $error("coded nibble fall half lane top bit set");
    ready_reset_a: assert property ($rose(rst_n_i) |-> ##[1:2] word_ready_o)
        else $error("ready late after reset");
    ready_drop_a: assert property ($fell(word_ready_o) && $past(rst_n_i) |-> $past(word_valid_i))
        else $error("ready fell without a push");
    ready_keep_a: assert property (word_ready_o && !word_valid_i |=> word_ready_o)
        else $error("ready fell while idle");
    idle_zero_a: assert property (idle_q > 8'hb0 |-> pins == 10'h000)
        else $error("pins not zero after the buffer ran dry");
endmodule : rpg_props

bind rpg_top rpg_props rpg_props_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rx_clk_i(rx_clk_i), .mode_i(mode_i),
    .code_en_pin_i(code_en_pin_i), .code_en_mgmt_i(code_en_mgmt_i),
    .word_valid_i(word_valid_i), .word_ready_o(word_ready_o),
    .rx_gh_low_bus_o(rx_gh_low_bus_o), .rx_gh_bit8_kflag_o(rx_gh_bit8_kflag_o),
    .rx_gh_bit9_o(rx_gh_bit9_o));

// ===== test/rpg_mac_model.sv
// far-side protocol device: makes the receive clock, captures both halves
`timescale 1ns/1ps
module rpg_mac_model (
    output logic             rx_clk_o,
    input  wire logic [9:0]  pins_i,
    output logic      [9:0]  fall_o,
    output logic      [9:0]  rise_o,
    output logic             pair_tgl_o
);
    initial
    begin
        rx_clk_o   = 1'b1;
        pair_tgl_o = 1'b0;
        fall_o     = 10'h000;
        rise_o     = 10'h000;
        // odd offset keeps link edges clear of core edges
        #7;
        forever #100 rx_clk_o = ~rx_clk_o;
    end
    // each half stands until the opposite edge, so take it there
    always @(posedge rx_clk_o)
        fall_o <= pins_i;
    always @(negedge rx_clk_o)
    begin
        rise_o     <= pins_i;
        pair_tgl_o <= ~pair_tgl_o;
    end
endmodule : rpg_mac_model

// ===== test/testbench.sv
// self-checking bench for the g/h receive upper-bit output block
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic        rx_clk;
    logic [1:0]  mode_i     = 2'h0;
    logic        code_pin   = 1'b0;
    logic        code_mgmt  = 1'b0;
    logic        valid      = 1'b0;
    logic [9:0]  g_word     = 10'h000;
    logic [9:0]  h_word     = 10'h000;
    logic        g_k        = 1'b0;
    logic        h_k        = 1'b0;
    logic        ready, bit8, bit9, tgl;
    logic [7:0]  low_bus;
    logic [9:0]  fall, rise;
    logic [19:0] exp_pair;
    logic [19:0] exp_q[$];
    int          err_total  = 0;
    int          checked    = 0;
    integer      seed       = 32'hb5a827d3;

    always #12.5 core_clk_i = ~core_clk_i;

    rpg_top rpg_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rx_clk_i(rx_clk),
        .mode_i(mode_i), .code_en_pin_i(code_pin), .code_en_mgmt_i(code_mgmt),
        .word_valid_i(valid), .g_word_i(g_word), .g_kflag_i(g_k), .h_word_i(h_word),
        .h_kflag_i(h_k), .word_ready_o(ready), .rx_gh_low_bus_o(low_bus),
        .rx_gh_bit8_kflag_o(bit8), .rx_gh_bit9_o(bit9));
    rpg_mac_model rpg_mac_model_inst (.rx_clk_o(rx_clk), .pins_i({bit9, bit8, low_bus}),
        .fall_o(fall), .rise_o(rise), .pair_tgl_o(tgl));

    // -----------------------------------------------------------------
    // reference layout and stimulus
    // -----------------------------------------------------------------
    function automatic logic [19:0] pair_of(logic [1:0] m, logic c, logic [9:0] g,
        logic gk, logic [9:0] h, logic hk);
        logic [9:0] f;
        logic [9:0] r;
        f = {h[4:0], g[4:0]};
        r = {h[9:5], g[9:5]};
        if (m == 2'h0)
        begin
            f = c ? {1'b0, gk, g[7:0]} : g;
            r = c ? {1'b0, hk, h[7:0]} : h;
        end
        else if (c)
        begin
            f = {1'b0, h[3:0], 1'b0, g[3:0]};
            r = {h[7], hk, h[6:4], g[7], gk, g[6:4]};
        end
        return {f, r};
    endfunction : pair_of

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // bit 0 of g is forced so a real pair never looks like an empty period
    task automatic burst(input int n);
        logic [9:0] gw;
        logic [9:0] hw;
        logic       gk;
        logic       hk;
        logic       rdy;
        int         w;
        for (int i = 0; i < n; i++)
        begin
            gw = 10'($random(seed)) | 10'h001;
            hw = 10'($random(seed));
            gk = 1'($random(seed));
            hk = 1'($random(seed));
            g_word <= gw;
            h_word <= hw;
            g_k    <= gk;
            h_k    <= hk;
            valid  <= 1'b1;
            w = 0;
            do
            begin
                @(negedge core_clk_i);
                rdy = ready;
                @(posedge core_clk_i);
                w++;
            end
            while (rdy !== 1'b1 && w < 300);
            // an unknown ready must not count as an accepted push
            if (rdy !== 1'b1)
            begin
                err_total++;
                test_done();
            end
            exp_q.push_back(pair_of(mode_i, code_pin | code_mgmt, gw, gk, hw, hk));
        end
        valid <= 1'b0;
    endtask : burst

    task automatic drain();
        int w;
        w = 0;
        while (exp_q.size() > 0 && w < 400)
        begin
            @(posedge core_clk_i);
            w++;
        end
        repeat (40) @(posedge core_clk_i);
        `CHK(exp_q.size(), 0)
        if (exp_q.size() > 0)
            test_done();
    endtask : drain

    // settle past the model's port updates before reading the pair
    always @(tgl)
    begin
        #1;
        if (rst_n_i === 1'b1 && {fall, rise} !== 20'h0)
        begin
            exp_pair = (exp_q.size() > 0) ? exp_q.pop_front() : 20'hfffff;
            `CHK({fall, rise}, exp_pair)
        end
    end

    // -----------------------------------------------------------------
    // main sequence: mux/nibble, coding off/pin/management, reserved
    // -----------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            mode_i    <= p[1] ? 2'h2 : 2'h0;
            code_pin  <= p[0] & ~p[1];
            code_mgmt <= p[0] & p[1];
            repeat (16) @(posedge core_clk_i);
            burst(24);
            drain();
        end
        // reserved code with words queued: pins must stay low while they drain
        mode_i <= 2'h1;
        repeat (16) @(posedge core_clk_i);
        burst(4);
        repeat (24)
        begin
            @(negedge core_clk_i);
            `CHK({bit9, bit8, low_bus}, 10'h000)
        end
        exp_q.delete();
        test_done();
    end
endmodule : testbench
